/* File: rtl/ubs_pkg.sv */
// constants shared by both ends of the serial port bus shell
// assumes a 10-bit word address bus and 16-bit data paths
package ubs_pkg;
   // ==========================================
   // bus geometry
   localparam int ADDR_MSB = 11;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W   = ADDR_MSB - ADDR_LSB + 1;
   localparam int DATA_W   = 16;
   // ==========================================
   // event lines
   localparam int IRQ_N      = 5;
   localparam int IRQ_MODEM  = 0;
   localparam int IRQ_RX     = 1;
   localparam int IRQ_TX     = 2;
   localparam int IRQ_RXTO   = 3;
   localparam int IRQ_ERR    = 4;
   localparam int DIR_TX     = 0;
   localparam int DIR_RX     = 1;
   localparam int EVT_N      = IRQ_N + 4;
   // ==========================================
   // shell status word, read at its own word address
   localparam logic [ADDR_W-1:0] STATUS_ADDR  = 10'h3ff;
   localparam int                STAT_IRQ_LSB = 0;
   localparam int                STAT_DMA_LSB = 5;
   // ==========================================
   // reset values and clock divider
   localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
   localparam int                SYNC_STAGES = 2;
   localparam int                PCLK_DIV    = 2;
endpackage

/* File: rtl/ubs_if.sv */
// link between the bus side master and the serial port shell
// assumes the master end makes the bus clock and both resets
`timescale 1ns/10ps
interface ubs_if;
   logic                              pclk;
   logic                              presetn;
   logic                              ref_domain_reset_n;
   logic                              psel;
   logic                              penable;
   logic                              pwrite;
   logic [ubs_pkg::ADDR_MSB:ubs_pkg::ADDR_LSB] paddr;
   logic [ubs_pkg::DATA_W-1:0]        pwdata;
   logic [ubs_pkg::DATA_W-1:0]        prdata;
   logic                              modem_status_irq;
   logic                              rx_fifo_irq;
   logic                              tx_fifo_irq;
   logic                              rx_timeout_irq;
   logic                              error_irq;
   logic                              combined_irq;
   logic                              tx_dma_single_req;
   logic                              rx_dma_single_req;
   logic                              tx_dma_burst_req;
   logic                              rx_dma_burst_req;
   logic                              tx_dma_req_clear;
   logic                              rx_dma_req_clear;

   modport device (
      input  pclk, presetn, ref_domain_reset_n, psel, penable, pwrite, paddr, pwdata,
      input  tx_dma_req_clear, rx_dma_req_clear,
      output prdata, modem_status_irq, rx_fifo_irq, tx_fifo_irq, rx_timeout_irq, error_irq,
      output combined_irq, tx_dma_single_req, rx_dma_single_req, tx_dma_burst_req, rx_dma_burst_req
   );
   modport host (
      output pclk, presetn, ref_domain_reset_n, psel, penable, pwrite, paddr, pwdata,
      output tx_dma_req_clear, rx_dma_req_clear,
      input  prdata, modem_status_irq, rx_fifo_irq, tx_fifo_irq, rx_timeout_irq, error_irq,
      input  combined_irq, tx_dma_single_req, rx_dma_single_req, tx_dma_burst_req, rx_dma_burst_req
   );
endinterface

/* File: rtl/ubs_reset_sync.sv */
// reset bridge: asserts at once, releases on the local clock
// assumes the incoming reset may come from any domain
`timescale 1ns/10ps
module ubs_reset_sync (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   output logic      o_rst_n
);
   logic meta_n;

   // ==========================================
   // assert without a clock, release after two edges
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_n  <= 1'b0;
         o_rst_n <= 1'b0;
      end else begin
         meta_n  <= 1'b1;
         o_rst_n <= meta_n;
      end
   end
endmodule

/* File: rtl/ubs_device.sv */
// serial port shell, device end: bus slave, interrupt and dma lines
// assumes the bus clock and both resets arrive over the link, and that
// i_core_clk is the free-running serial reference clock
// Summary of operation
// - bus reset is active low
// - bus sampled and driven on bus clock
// - master holds enable for one cycle
// - select low means bus ignored
// - write high, read low
// - decode only word address bits
// - sixteen-bit separate read and write data
// - reference clock supplied, free running
// - synchronise every crossing between domains
// - reset asserts async, releases on own clock
// - reset works with clocks stopped
// - each domain has own reset input
// - five active-high interrupt outputs
// - combined interrupt is OR of five
// - single dma requests per direction
// - burst dma requests per direction
// - clear input drops that direction's requests
`timescale 1ns/10ps
module ubs_device (
   input  wire logic                          i_core_clk,
   ubs_if.device                              link,
   input  wire logic [ubs_pkg::IRQ_N-1:0]     i_irq_src,
   input  wire logic [1:0]                    i_dma_single_src,
   input  wire logic [1:0]                    i_dma_burst_src,
   input  wire logic [ubs_pkg::DATA_W-1:0]    i_bus_rdata,
   output logic                               o_bus_wr,
   output logic                               o_bus_rd,
   output logic [ubs_pkg::ADDR_W-1:0]         o_bus_addr,
   output logic [ubs_pkg::DATA_W-1:0]         o_bus_wdata,
   output logic [1:0]                         o_dma_clear
);
   // ==========================================
   // reset bridges
   logic                          p_rst_n;
   logic                          r_rst_n;
   // ==========================================
   // crossing state
   logic [ubs_pkg::EVT_N-1:0]     src_q;
   logic [ubs_pkg::EVT_N-1:0]     evt_meta;
   logic [ubs_pkg::EVT_N-1:0]     evt_sync;
   logic [ubs_pkg::EVT_N-1:0]     evt_prev;
   logic [1:0]                    clr_tgl;
   logic [1:0]                    clr_meta;
   logic [1:0]                    clr_sync;
   logic [1:0]                    clr_prev;
   // ==========================================
   // bus and request state
   logic [ubs_pkg::IRQ_N-1:0]     irq;
   logic [1:0]                    sreq;
   logic [1:0]                    breq;
   logic                          access_rd;
   logic [ubs_pkg::DATA_W-1:0]    status_word;

   ubs_reset_sync u_prst (
      .i_clk    (link.pclk),
      .i_arst_n (link.presetn),
      .o_rst_n  (p_rst_n)
   );

   ubs_reset_sync u_rrst (
      .i_clk    (i_core_clk),
      .i_arst_n (link.ref_domain_reset_n),
      .o_rst_n  (r_rst_n)
   );

   // ==========================================
   // reference domain: register the event sources
   // relies on running clock
   always_ff @(posedge i_core_clk or negedge r_rst_n) begin
      if (!r_rst_n) begin
         src_q <= '0;
      end else begin
         src_q <= {i_dma_burst_src, i_dma_single_src, i_irq_src};
      end
   end

   // ==========================================
   // bus domain: two-flop synchronisers per event
   // synchronise each event line
   genvar gi;
   generate
      for (gi = 0; gi < ubs_pkg::EVT_N; gi++) begin : g_evt
         always_ff @(posedge link.pclk or negedge p_rst_n) begin
            if (!p_rst_n) begin
               evt_meta[gi] <= 1'b0;
               evt_sync[gi] <= 1'b0;
               evt_prev[gi] <= 1'b0;
            end else begin
               evt_meta[gi] <= src_q[gi];
               evt_sync[gi] <= evt_meta[gi];
               evt_prev[gi] <= evt_sync[gi];
            end
         end
      end
   endgenerate

   // ==========================================
   // interrupt outputs
   // five separate interrupt levels
   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         irq <= '0;
      end else begin
         irq <= evt_sync[ubs_pkg::IRQ_N-1:0];
      end
   end

   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         link.combined_irq <= 1'b0;
      end else begin
         link.combined_irq <= |evt_sync[ubs_pkg::IRQ_N-1:0];
      end
   end

   assign link.modem_status_irq = irq[ubs_pkg::IRQ_MODEM];
   assign link.rx_fifo_irq      = irq[ubs_pkg::IRQ_RX];
   assign link.tx_fifo_irq      = irq[ubs_pkg::IRQ_TX];
   assign link.rx_timeout_irq   = irq[ubs_pkg::IRQ_RXTO];
   assign link.error_irq        = irq[ubs_pkg::IRQ_ERR];

   // ==========================================
   // dma requests: raised on a source rising edge,
   // dropped by the clear; a new edge beats a clear
   // single requests per direction
   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         sreq <= '0;
      end else begin
         for (int d = 0; d < 2; d++) begin
            if (evt_sync[ubs_pkg::IRQ_N+d] && !evt_prev[ubs_pkg::IRQ_N+d]) begin
               sreq[d] <= 1'b1;
            end else if ((d == ubs_pkg::DIR_TX) ? link.tx_dma_req_clear : link.rx_dma_req_clear) begin
               sreq[d] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         breq <= '0;
      end else begin
         for (int d = 0; d < 2; d++) begin
            if (evt_sync[ubs_pkg::IRQ_N+2+d] && !evt_prev[ubs_pkg::IRQ_N+2+d]) begin
               breq[d] <= 1'b1;
            end else if ((d == ubs_pkg::DIR_TX) ? link.tx_dma_req_clear : link.rx_dma_req_clear) begin
               breq[d] <= 1'b0;
            end
         end
      end
   end

   assign link.tx_dma_single_req = sreq[ubs_pkg::DIR_TX];
   assign link.rx_dma_single_req = sreq[ubs_pkg::DIR_RX];
   assign link.tx_dma_burst_req  = breq[ubs_pkg::DIR_TX];
   assign link.rx_dma_burst_req  = breq[ubs_pkg::DIR_RX];

   // ==========================================
   // clears back to the serial side by toggle,
   // since a one-cycle bus pulse could be missed
   // toggle crossing for clears
   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         clr_tgl <= '0;
      end else begin
         clr_tgl <= clr_tgl ^ {link.rx_dma_req_clear, link.tx_dma_req_clear};
      end
   end

   always_ff @(posedge i_core_clk or negedge r_rst_n) begin
      if (!r_rst_n) begin
         clr_meta    <= '0;
         clr_sync    <= '0;
         clr_prev    <= '0;
         o_dma_clear <= '0;
      end else begin
         clr_meta    <= clr_tgl;
         clr_sync    <= clr_meta;
         clr_prev    <= clr_sync;
         o_dma_clear <= clr_sync ^ clr_prev;
      end
   end

   // ==========================================
   // bus slave
   // all bus logic on bus clock
   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         o_bus_addr <= '0;
      end else begin
         if (link.psel && !link.penable) begin
            o_bus_addr <= link.paddr;
         end
      end
   end

   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         o_bus_wr    <= 1'b0;
         o_bus_rd    <= 1'b0;
         o_bus_wdata <= ubs_pkg::DATA_RESET;
      end else begin
         o_bus_wr <= link.psel && link.penable && link.pwrite;
         o_bus_rd <= link.psel && !link.penable && !link.pwrite;
         if (link.psel && link.penable && link.pwrite) begin
            o_bus_wdata <= link.pwdata;
         end
      end
   end

   // read data valid through the access cycle
   // relies on single access cycle
   always_ff @(posedge link.pclk or negedge p_rst_n) begin
      if (!p_rst_n) begin
         access_rd <= 1'b0;
      end else begin
         access_rd <= link.psel && !link.pwrite;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[ubs_pkg::STAT_IRQ_LSB +: ubs_pkg::IRQ_N] = irq;
      status_word[ubs_pkg::STAT_DMA_LSB +: 4]              = {breq, sreq};
   end

   always_comb begin
      link.prdata = ubs_pkg::DATA_RESET;
      if (access_rd && link.penable && (o_bus_addr == ubs_pkg::STATUS_ADDR)) begin
         link.prdata = status_word;
      end else if (access_rd && link.penable) begin
         link.prdata = i_bus_rdata;
      end
   end

endmodule

/* File: rtl/ubs_host.sv */
// bus master, reset controller and dma / interrupt receiver end
// assumes i_core_clk makes the bus clock and i_ref_clk is the serial clock
`timescale 1ns/10ps
module ubs_host (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_srst,
   input  wire logic                       i_ref_clk,
   ubs_if.host                             link,
   input  wire logic                       i_req_valid,
   input  wire logic                       i_req_write,
   input  wire logic [ubs_pkg::ADDR_W-1:0] i_req_addr,
   input  wire logic [ubs_pkg::DATA_W-1:0] i_req_wdata,
   input  wire logic [1:0]                 i_dma_clear,
   output logic                            o_req_ready,
   output logic                            o_rsp_valid,
   output logic [ubs_pkg::DATA_W-1:0]      o_rsp_rdata,
   output logic [ubs_pkg::IRQ_N-1:0]       o_irq,
   output logic                            o_combined_irq,
   output logic [3:0]                      o_dma_req
);
   typedef enum logic [1:0] {UBS_IDLE, UBS_SETUP, UBS_ACCESS} ubs_state_t;
   ubs_state_t   state;
   logic         pclk_q;
   logic         tick;
   logic [1:0]   clr_pend;
   logic [9:0]   in_meta;
   logic [9:0]   in_sync;
   logic         write_q;

   // ==========================================
   // bus clock by divide-by-two; tick marks its falling edge
   assign tick = pclk_q;
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         pclk_q       <= 1'b0;
         link.presetn <= 1'b0;
      end else begin
         pclk_q       <= !pclk_q;
         link.presetn <= 1'b1;
      end
   end
   assign link.pclk = pclk_q;

   ubs_reset_sync u_rrst (
      .i_clk    (i_ref_clk),
      .i_arst_n (link.presetn),
      .o_rst_n  (link.ref_domain_reset_n)
   );

   // ==========================================
   // bus master; changes only at bus clock falling edges
   // enable for one bus cycle
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state        <= UBS_IDLE;
         link.psel    <= 1'b0;
         link.penable <= 1'b0;
         link.pwrite  <= 1'b0;
         link.paddr   <= '0;
         link.pwdata  <= ubs_pkg::DATA_RESET;
         o_req_ready  <= 1'b0;
         o_rsp_valid  <= 1'b0;
         o_rsp_rdata  <= ubs_pkg::DATA_RESET;
         write_q      <= 1'b0;
      end else begin
         o_rsp_valid <= 1'b0;
         o_req_ready <= 1'b0;
         case (state)
            UBS_IDLE: begin
               if (tick && i_req_valid) begin
                  link.psel   <= 1'b1;
                  link.pwrite <= i_req_write;
                  link.paddr  <= i_req_addr;
                  link.pwdata <= i_req_wdata;
                  write_q     <= i_req_write;
                  o_req_ready <= 1'b1;
                  state       <= UBS_SETUP;
               end
            end
            UBS_SETUP: begin
               if (tick) begin
                  link.penable <= 1'b1;
                  state        <= UBS_ACCESS;
               end
            end
            UBS_ACCESS: begin
               if (tick) begin
                  link.psel    <= 1'b0;
                  link.penable <= 1'b0;
                  o_rsp_valid  <= 1'b1;
                  if (!write_q) begin
                     o_rsp_rdata <= link.prdata;
                  end
                  state <= UBS_IDLE;
               end
            end
            default: begin
               state <= UBS_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // clears held one whole bus cycle; a new request is kept
   // clear pulsed per direction
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         clr_pend              <= '0;
         link.tx_dma_req_clear <= 1'b0;
         link.rx_dma_req_clear <= 1'b0;
      end else begin
         if (tick) begin
            link.tx_dma_req_clear <= clr_pend[ubs_pkg::DIR_TX] | i_dma_clear[ubs_pkg::DIR_TX];
            link.rx_dma_req_clear <= clr_pend[ubs_pkg::DIR_RX] | i_dma_clear[ubs_pkg::DIR_RX];
            clr_pend              <= '0;
         end else begin
            clr_pend <= clr_pend | i_dma_clear;
         end
      end
   end

   // ==========================================
   // device outputs pass two flops before use
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         in_meta        <= '0;
         in_sync        <= '0;
         o_irq          <= '0;
         o_combined_irq <= 1'b0;
         o_dma_req      <= '0;
      end else begin
         in_meta        <= {link.rx_dma_burst_req, link.tx_dma_burst_req,
                            link.rx_dma_single_req, link.tx_dma_single_req, link.combined_irq,
                            link.error_irq, link.rx_timeout_irq, link.tx_fifo_irq,
                            link.rx_fifo_irq, link.modem_status_irq};
         in_sync        <= in_meta;
         o_irq          <= in_sync[4:0];
         o_combined_irq <= in_sync[5];
         o_dma_req      <= in_sync[9:6];
      end
   end
endmodule

/* File: verif/ubs_link_assertions.sv */
// concurrent checks on the link between host and device ends
// assumes the bench feeds it the interface signals by name
`timescale 1ns/10ps
module ubs_link_assertions (
   input wire logic                                       pclk,
   input wire logic                                       presetn,
   input wire logic                                       ref_domain_reset_n,
   input wire logic                                       psel,
   input wire logic                                       penable,
   input wire logic                                       pwrite,
   input wire logic [ubs_pkg::ADDR_MSB:ubs_pkg::ADDR_LSB] paddr,
   input wire logic [ubs_pkg::DATA_W-1:0]                 pwdata,
   input wire logic [ubs_pkg::DATA_W-1:0]                 prdata,
   input wire logic                                       modem_status_irq,
   input wire logic                                       rx_fifo_irq,
   input wire logic                                       tx_fifo_irq,
   input wire logic                                       rx_timeout_irq,
   input wire logic                                       error_irq,
   input wire logic                                       combined_irq,
   input wire logic                                       tx_dma_single_req,
   input wire logic                                       rx_dma_single_req,
   input wire logic                                       tx_dma_burst_req,
   input wire logic                                       rx_dma_burst_req,
   input wire logic                                       tx_dma_req_clear,
   input wire logic                                       rx_dma_req_clear
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====================
   // bus handshake
   enable_one_a: assert property (penable |=> !penable)
      else $error("enable held past one cycle");
   setup_access_a: assert property (psel && !penable |=> psel && penable && $stable(paddr) && $stable(pwrite))
      else $error("setup not followed by matching access");
   access_hold_a: assert property (psel && penable |-> $stable(pwdata) && $stable(paddr))
      else $error("address or write data moved in access");
   idle_enable_a: assert property (!psel |-> !penable)
      else $error("enable without select");
   prdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 16'h0000)
      else $error("read data driven outside read access");
   // ====================
   // events; the combined line is a flop, so same-cycle equality holds
   combined_or_a: assert property (combined_irq == (modem_status_irq | rx_fifo_irq | tx_fifo_irq | rx_timeout_irq | error_irq))
      else $error("combined interrupt is not the or of five");
   tx_clear_a: assert property ($rose(tx_dma_req_clear) |-> ##[1:2] !(tx_dma_single_req || tx_dma_burst_req))
      else $error("tx requests not dropped by clear");
   rx_clear_a: assert property ($rose(rx_dma_req_clear) |-> ##[1:2] !(rx_dma_single_req || rx_dma_burst_req))
      else $error("rx requests not dropped by clear");
   clear_pulse_a: assert property ($rose(tx_dma_req_clear) || $rose(rx_dma_req_clear) |=> !tx_dma_req_clear && !rx_dma_req_clear)
      else $error("clear longer than one cycle");
   tx_sticky_a: assert property ($fell(tx_dma_single_req) || $fell(tx_dma_burst_req) |-> $past(tx_dma_req_clear) || $past(tx_dma_req_clear, 2))
      else $error("tx request fell without clear");
   rx_sticky_a: assert property ($fell(rx_dma_single_req) || $fell(rx_dma_burst_req) |-> $past(rx_dma_req_clear) || $past(rx_dma_req_clear, 2))
      else $error("rx request fell without clear");
   // reset check cannot be gated by the reset it watches
   ref_reset_a: assert property (disable iff (1'b0) !presetn |-> !ref_domain_reset_n)
      else $error("reference reset high while bus reset low");
endmodule

/* File: verif/uart_bus_irq_dma_shell_bench.sv */
// self-checking bench: host and device ends joined by the link
// assumes both ends and the link checker compile before it
`timescale 1ns/10ps
module uart_bus_irq_dma_shell_bench;
   logic        core_clk = 1'b0;
   logic        ref_clk  = 1'b0;
   logic        srst     = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [9:0]  req_addr  = 10'h000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0]  dma_clr   = 2'b00;
   logic [4:0]  irq_src   = 5'h00;
   logic [1:0]  sgl_src   = 2'b00;
   logic [1:0]  bst_src   = 2'b00;
   logic        req_ready, rsp_valid, comb_irq, bus_wr, bus_rd;
   logic [15:0] rsp_rdata, bus_rdata, bus_wdata, wr_d;
   logic [4:0]  irq;
   logic [3:0]  dma_req;
   logic [9:0]  bus_addr, wr_a;
   logic [1:0]  dev_clr;
   int          wr_cnt = 0, rd_cnt = 0, ctx = 0, crx = 0;
   int          err_total = 0, checks_done = 0;
   ubs_if link();
   ubs_host u_ubs_host (.i_core_clk(core_clk), .i_srst(srst), .i_ref_clk(ref_clk), .link(link),
      .i_req_valid(req_valid), .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
      .i_dma_clear(dma_clr), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata),
      .o_irq(irq), .o_combined_irq(comb_irq), .o_dma_req(dma_req));
   ubs_device u_ubs_device (.i_core_clk(ref_clk), .link(link), .i_irq_src(irq_src), .i_dma_single_src(sgl_src),
      .i_dma_burst_src(bst_src), .i_bus_rdata(bus_rdata), .o_bus_wr(bus_wr), .o_bus_rd(bus_rd),
      .o_bus_addr(bus_addr), .o_bus_wdata(bus_wdata), .o_dma_clear(dev_clr));
   ubs_link_assertions u_ubs_link_assertions (.pclk(link.pclk), .presetn(link.presetn),
      .ref_domain_reset_n(link.ref_domain_reset_n), .psel(link.psel), .penable(link.penable),
      .pwrite(link.pwrite), .paddr(link.paddr), .pwdata(link.pwdata), .prdata(link.prdata),
      .modem_status_irq(link.modem_status_irq), .rx_fifo_irq(link.rx_fifo_irq),
      .tx_fifo_irq(link.tx_fifo_irq), .rx_timeout_irq(link.rx_timeout_irq), .error_irq(link.error_irq),
      .combined_irq(link.combined_irq), .tx_dma_single_req(link.tx_dma_single_req),
      .rx_dma_single_req(link.rx_dma_single_req), .tx_dma_burst_req(link.tx_dma_burst_req),
      .rx_dma_burst_req(link.rx_dma_burst_req), .tx_dma_req_clear(link.tx_dma_req_clear),
      .rx_dma_req_clear(link.rx_dma_req_clear));
   // ====================
   // clocks, register file stand-in and recorders
   always #5 core_clk = ~core_clk;
   initial begin
      #2.5;
      forever #6 ref_clk = ~ref_clk;
   end
   assign bus_rdata = {bus_addr[5:0], bus_addr};
   always @(posedge link.pclk) begin
      if (bus_wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         wr_a   <= bus_addr;
         wr_d   <= bus_wdata;
      end
      if (bus_rd === 1'b1) rd_cnt <= rd_cnt + 1;
   end
   always @(posedge ref_clk) begin
      if (dev_clr[0] === 1'b1) ctx <= ctx + 1;
      if (dev_clr[1] === 1'b1) crx <= crx + 1;
   end
   // ====================
   // shared tasks
   task automatic report_and_stop;
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      do begin @(negedge core_clk); n++; end while (req_ready !== 1'b1 && n < 40);
      @(posedge core_clk);
      req_valid <= 1'b0;
      do begin @(negedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 80);
      if (n >= 80) begin
         err_total++;
         report_and_stop();
      end
   endtask
   // events word is {combined, five irqs, rx_b, tx_b, rx_s, tx_s}
   task automatic expect_ev(input logic [9:0] exp);
      for (int n = 0; n < 100 && {comb_irq, irq, dma_req} !== exp; n++) @(negedge core_clk);
      chk("events", {6'h00, comb_irq, irq, dma_req}, {6'h00, exp});
   endtask
   // ====================
   // scenarios
   task automatic t_wr_rd;
      logic [9:0] at [3] = '{10'h000, 10'h155, 10'h2aa};
      int         w0, r0;
      for (int k = 0; k < 3; k++) begin
         w0 = wr_cnt;
         r0 = rd_cnt;
         xfer(1'b1, at[k], {~at[k][5:0], ~at[k]});
         for (int n = 0; n < 20 && wr_cnt == w0; n++) @(negedge core_clk);
         chk("wr count", 16'(wr_cnt - w0), 16'h0001);
         chk("wr addr", {6'h00, wr_a}, {6'h00, at[k]});
         chk("wr data", wr_d, {~at[k][5:0], ~at[k]});
         xfer(1'b0, at[k], 16'h0000);
         chk("rd data", rsp_rdata, {at[k][5:0], at[k]});
         chk("rd count", 16'(rd_cnt - r0), 16'h0001);
      end
   endtask
   task automatic t_irq;
      for (int k = 0; k < 5; k++) begin
         @(posedge core_clk) irq_src <= 5'(1 << k);
         expect_ev({1'b1, 5'(1 << k), 4'h0});
      end
      xfer(1'b0, ubs_pkg::STATUS_ADDR, 16'h0000);
      chk("status irq", rsp_rdata, 16'h0010);
      @(posedge core_clk) irq_src <= 5'h00;
      expect_ev(10'h000);
   endtask
   task automatic t_dma;
      int c0;
      @(posedge core_clk);
      sgl_src <= 2'b01;
      bst_src <= 2'b10;
      expect_ev(10'b0_00000_1001);
      xfer(1'b0, ubs_pkg::STATUS_ADDR, 16'h0000);
      chk("status dma", rsp_rdata, 16'h0120);
      c0 = ctx;
      @(posedge core_clk) dma_clr <= 2'b01;
      @(posedge core_clk) dma_clr <= 2'b00;
      // sources still high: edge-set requests must not come back
      expect_ev(10'b0_00000_1000);
      for (int n = 0; n < 20 && ctx == c0; n++) @(negedge core_clk);
      chk("clear pulses", 16'(ctx - c0), 16'h0001);
      c0 = crx;
      @(posedge core_clk) dma_clr <= 2'b10;
      @(posedge core_clk) dma_clr <= 2'b00;
      expect_ev(10'h000);
      for (int n = 0; n < 20 && crx == c0; n++) @(negedge core_clk);
      chk("rx clears", 16'(crx - c0), 16'h0001);
      @(posedge core_clk);
      sgl_src <= 2'b00;
      bst_src <= 2'b00;
   endtask
   task automatic t_reset;
      @(posedge core_clk) irq_src <= 5'h1f;
      expect_ev({1'b1, 5'h1f, 4'h0});
      @(posedge core_clk) srst <= 1'b1;
      repeat (20) @(posedge core_clk);
      // bus clock is stopped here, so only an async reset clears the device
      @(negedge core_clk);
      chk("in reset", {7'h00, link.presetn, link.ref_domain_reset_n, link.combined_irq, comb_irq, irq},
          16'h0000);
      @(posedge core_clk) srst <= 1'b0;
      expect_ev({1'b1, 5'h1f, 4'h0});
      @(posedge core_clk) irq_src <= 5'h00;
      expect_ev(10'h000);
   endtask
   // ====================
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      repeat (20) @(posedge core_clk);
      t_wr_rd();
      t_irq();
      t_dma();
      t_reset();
      t_wr_rd();
      report_and_stop();
   end
endmodule
